/* File: verilog/state_word_decoder.sv */
/*
  Sequencing engine state-word decoder: monitor faults, timeout, advance
  condition and delay, jump priority, interchip ping/pong and broadcast.
  Assumes fault comparator outputs and link strobes are synchronous to mclk.
*/
// Notes on behaviour
// R1: Bit 27 unmasks fourth dual input fault
// R2: Bit 28 polarity of fifth input, gated by 29
// R3: Bit 30 unmasks warning, fault on high
// R4: Bits 31-34 select timeout length
// R5: Code zero disables timeout, zero delay
// R6: Codes 1-15 map to delay table
// R7: Bits 35-38 select advance source
// R8: Writer keeps polarity 0 when source 0
// R9: Source 12 waits for host jump command
// R10: Bit 39 low-active advance when set
// R11: Bits 40-43 advance delay before jump
// R12: Source 14 sends ping to address
// R13: Source 15 waits ping, sends pong
// R14: Delay field used directly as address
// R15: Monitor fault jumps to bits 44-49
// R16: Timeout jumps to bits 50-55
// R17: Advance jumps to bits 56-61
// R18: Round robin is bit 62 OR global
// R19: Bit 63 broadcasts on local advance
// R20: Channel polarity effective only when unmasked
// R21: Host step forces advance, self clears
// R22: 64 words indexed by current state
// R23: Monitor beats timeout beats advance
// R24: Counts restart on every state entry
`timescale 1ns/1ps
module state_word_decoder #(
  parameter int NSTATE = seq_word_pkg::NUM_STATES,
  parameter int WBITS  = seq_word_pkg::WORD_BITS,
  parameter int SBITS  = seq_word_pkg::STATE_BITS
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             cfg_wr_en,
  input  wire logic [SBITS-1:0] cfg_wr_addr,
  input  wire logic [WBITS-1:0] cfg_wr_data,
  input  wire logic [3:0]       positive_supply_inputs,
  input  wire logic             high_voltage_input,
  input  wire logic [4:0]       dual_function_inputs,
  input  wire logic             warning,
  input  wire logic             halt,
  input  wire logic             host_jump,
  input  wire logic             global_rr_en,
  input  wire logic             ping_rx,
  input  wire logic [3:0]       ping_rx_addr,
  input  wire logic [3:0]       own_link_addr,
  output logic      [SBITS-1:0] current_state,
  output logic                  host_jump_pending,
  output logic                  monitor_fault,
  output logic                  round_robin_en,
  output logic                  ping_tx,
  output logic                  pong_tx,
  output logic      [3:0]       msg_addr,
  output logic                  broadcast_tx
);

  logic [SBITS-1:0] state_r;
  logic [SBITS-1:0] state_nxt;
  logic [WBITS-1:0] word;
  logic             word_valid_r;
  logic             entry_r;
  logic             host_jump_r;
  logic             ping_tx_r;
  logic             pong_tx_r;
  logic             bcast_r;
  logic [3:0]       msg_addr_r;
  seq_word_pkg::link_state_t link_r;
  seq_word_pkg::link_state_t link_nxt;

  // Word for the current state
  state_word_mem #(
    .DEPTH (NSTATE),
    .WIDTH (WBITS),
    .AW    (SBITS)
  ) u_mem (
    .mclk    (mclk),
    .wr_en   (cfg_wr_en),
    .wr_addr (cfg_wr_addr),
    .wr_data (cfg_wr_data),
    .rd_addr (state_nxt),
    .rd_data (word)
  ); // R22

  // Field extraction
  wire [3:0]       wait_code  = word[seq_word_pkg::WAIT_CODE_LSB +: 4];   // R4
  wire [3:0]       src_sel    = word[seq_word_pkg::SRC_SEL_LSB +: 4];     // R7
  wire             adv_pol    = word[seq_word_pkg::ADV_POL_BIT];          // R10
  wire [3:0]       delay_code = word[seq_word_pkg::DELAY_CODE_LSB +: 4];  // R11
  wire [SBITS-1:0] mon_tgt    = word[seq_word_pkg::MON_TGT_LSB +: SBITS]; // R15
  wire [SBITS-1:0] exp_tgt    = word[seq_word_pkg::EXP_TGT_LSB +: SBITS]; // R16
  wire [SBITS-1:0] adv_tgt    = word[seq_word_pkg::ADV_TGT_LSB +: SBITS]; // R17

  // Per-channel fault: polarity bit then unmask bit
  wire [seq_word_pkg::NUM_CHAN-1:0] chan_in = {dual_function_inputs, high_voltage_input,
                                               positive_supply_inputs};
  wire [seq_word_pkg::NUM_CHAN-1:0] chan_fault;

  genvar gi;
  generate
    for (gi = 0; gi < seq_word_pkg::NUM_CHAN; gi++) begin : g_chan
      wire pol    = word[seq_word_pkg::VP_POL_LSB + 2*gi];
      wire unmask = word[seq_word_pkg::VP_POL_LSB + 2*gi + 1];
      // Bits 27 and 28/29 fall on channels 8 and 9
      assign chan_fault[gi] = unmask && (chan_in[gi] == pol); // R1 R2 R20
    end
  endgenerate

  wire warn_fault = word[seq_word_pkg::WARN_UNMASK_BIT] && warning; // R3
  wire mon_fault  = word_valid_r && ((|chan_fault) || warn_fault);

  // Advance source selection
  wire [15:0] src_vec = {3'b000, host_jump_r, warning, dual_function_inputs,
                         high_voltage_input, positive_supply_inputs, 1'b0};
  wire        src_lvl = src_vec[src_sel]; // R7
  wire        is_link = (src_sel == seq_word_pkg::SRC_PING) ||
                        (src_sel == seq_word_pkg::SRC_PONG);
  // Source 0 with polarity 0 reads 0 and never advances; writer keeps that setting
  wire        cond_lvl = is_link ? (link_r == seq_word_pkg::LINK_DONE)
                                 : (src_lvl ^ adv_pol); // R8 R9 R10

  // Timers restart on entry
  wire wait_en = word_valid_r && (wait_code != seq_word_pkg::CODE_NONE); // R5
  wire timeout_hit;
  wire delay_done;

  delay_timer u_timeout (
    .mclk    (mclk),
    .reset   (reset),
    .clear   (entry_r),
    .run     (wait_en),
    .code    (wait_code),
    .expired (timeout_hit)
  ); // R4 R6 R24

  // Advance delay runs while condition holds; code 0 gives zero delay
  delay_timer u_delay (
    .mclk    (mclk),
    .reset   (reset),
    .clear   (entry_r),
    .run     (word_valid_r && cond_lvl && !is_link),
    .code    (delay_code),
    .expired (delay_done)
  ); // R5 R6 R11 R24

  wire seq_hit  = is_link ? cond_lvl : delay_done; // R11
  wire step_hit = host_jump_r && (src_sel != seq_word_pkg::SRC_HOST);
  wire run_ok   = word_valid_r && !halt;

  // Priority: monitor fault, timeout, sequence, host step
  wire take_mon  = run_ok && mon_fault;                         // R23
  wire take_exp  = run_ok && !mon_fault && timeout_hit;         // R23
  wire take_seq  = run_ok && !mon_fault && !timeout_hit && seq_hit;
  wire take_step = run_ok && !mon_fault && !timeout_hit && !seq_hit && step_hit;
  wire moving    = take_mon || take_exp || take_seq || take_step;

  always_comb begin
    state_nxt = state_r;
    if (take_mon) begin
      state_nxt = mon_tgt;                   // R15
    end else if (take_exp) begin
      state_nxt = exp_tgt;                   // R16
    end else if (take_seq) begin
      state_nxt = adv_tgt;                   // R17
    end else if (take_step) begin
      state_nxt = state_r + SBITS'(1);       // R21
    end
  end

  // Ping/pong link sequence
  wire ping_match = ping_rx && (ping_rx_addr == own_link_addr);

  always_comb begin
    link_nxt = link_r;
    case (link_r)
      seq_word_pkg::LINK_IDLE: begin
        if (word_valid_r && src_sel == seq_word_pkg::SRC_PING) begin
          link_nxt = seq_word_pkg::LINK_DONE;        // R12
        end else if (word_valid_r && src_sel == seq_word_pkg::SRC_PONG) begin
          link_nxt = seq_word_pkg::LINK_WAIT_PING;
        end
      end
      seq_word_pkg::LINK_WAIT_PING: begin
        if (ping_match) begin
          link_nxt = seq_word_pkg::LINK_DONE;        // R13
        end
      end
      seq_word_pkg::LINK_DONE: begin
        link_nxt = seq_word_pkg::LINK_DONE;
      end
      default: begin
        link_nxt = seq_word_pkg::LINK_IDLE;
      end
    endcase
  end

  wire send_ping = (link_r == seq_word_pkg::LINK_IDLE) && word_valid_r &&
                   (src_sel == seq_word_pkg::SRC_PING);
  wire send_pong = (link_r == seq_word_pkg::LINK_WAIT_PING) && ping_match;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r      <= seq_word_pkg::RESET_STATE;
      word_valid_r <= 1'b0;
      entry_r      <= 1'b1;
      link_r       <= seq_word_pkg::LINK_IDLE;
    end else begin
      state_r      <= state_nxt;             // R22
      word_valid_r <= !moving;
      entry_r      <= moving;                // R24
      link_r       <= moving ? seq_word_pkg::LINK_IDLE : link_nxt;
    end
  end

  // Host jump request: held until a state change, set wins over clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      host_jump_r <= 1'b0;
    end else if (host_jump) begin
      host_jump_r <= 1'b1;                   // R9 R21
    end else if (moving) begin
      host_jump_r <= 1'b0;                   // R21
    end
  end

  // Link and broadcast strobes
  always_ff @(posedge mclk) begin
    if (reset) begin
      ping_tx_r  <= 1'b0;
      pong_tx_r  <= 1'b0;
      bcast_r    <= 1'b0;
      msg_addr_r <= 4'h0;
    end else begin
      ping_tx_r  <= send_ping && !moving;    // R12
      pong_tx_r  <= send_pong && !moving;    // R13
      bcast_r    <= take_seq && word[seq_word_pkg::BCAST_BIT]; // R19
      if (send_ping || send_pong) begin
        msg_addr_r <= delay_code;            // R14
      end
    end
  end

  assign current_state     = state_r;
  assign host_jump_pending = host_jump_r;
  assign monitor_fault     = mon_fault;
  assign round_robin_en    = (word_valid_r && word[seq_word_pkg::RR_EN_BIT]) ||
                             global_rr_en;   // R18
  assign ping_tx           = ping_tx_r;
  assign pong_tx           = pong_tx_r;
  assign msg_addr          = msg_addr_r;
  assign broadcast_tx      = bcast_r;

endmodule : state_word_decoder

/* File: verilog/seq_word_pkg.sv */
/*
  Package: state-word field layout, delay table, source codes and timing constants
  for the sequencing engine state word decoder.
  Assumes a 100 MHz clock; all counts derive from that rate.
*/
package seq_word_pkg;

  localparam int STATE_BITS     = 6;
  localparam int NUM_STATES     = 64;
  localparam int WORD_BITS      = 64;

  // Field positions in the state word
  localparam int VP_POL_LSB     = 10;
  localparam int VX4_UNMASK_BIT = 27;
  localparam int VX5_POL_BIT    = 28;
  localparam int VX5_UNMASK_BIT = 29;
  localparam int WARN_UNMASK_BIT = 30;
  localparam int WAIT_CODE_LSB  = 31;
  localparam int SRC_SEL_LSB    = 35;
  localparam int ADV_POL_BIT    = 39;
  localparam int DELAY_CODE_LSB = 40;
  localparam int MON_TGT_LSB    = 44;
  localparam int EXP_TGT_LSB    = 50;
  localparam int ADV_TGT_LSB    = 56;
  localparam int RR_EN_BIT      = 62;
  localparam int BCAST_BIT      = 63;

  localparam int NUM_CHAN       = 10;

  // Advance source select codes
  localparam logic [3:0] SRC_NEVER    = 4'h0;
  localparam logic [3:0] SRC_POS_LO   = 4'h1;
  localparam logic [3:0] SRC_WARNING  = 4'hb;
  localparam logic [3:0] SRC_HOST     = 4'hc;
  localparam logic [3:0] SRC_PING     = 4'he;
  localparam logic [3:0] SRC_PONG     = 4'hf;
  localparam logic [3:0] CODE_NONE    = 4'h0;

  localparam logic [STATE_BITS-1:0] RESET_STATE = 6'h00;

  // Delay table in microseconds (code 0 gives zero delay)
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_US [16] = '{0, 100, 200, 400, 700, 1000, 2000, 4000, 7000,
                                   10000, 20000, 40000, 70000, 100000, 200000, 400000};
  localparam int CNT_BITS = 26;

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_WAIT_PING,
    LINK_DONE
  } link_state_t;

endpackage : seq_word_pkg

/* File: verilog/state_word_mem.sv */
/*
  State definition memory: one word per state, registered read.
  Assumes a configuration loader writes words before sequencing starts.
*/
`timescale 1ns/1ps
module state_word_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             mclk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : state_word_mem

/* File: verilog/delay_timer.sv */
/*
  Delay timer: counts cycles against the mapped code; restarts on clear.
  Assumes a synchronous active-high reset and 100 MHz mclk.
*/
`timescale 1ns/1ps
module delay_timer #(
  parameter int CW = seq_word_pkg::CNT_BITS
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          clear,
  input  wire logic          run,
  input  wire logic [3:0]    code,
  output logic               expired
);
  logic [CW-1:0] count_r;
  logic [CW-1:0] limit;

  // Microseconds times cycles per microsecond
  assign limit = CW'(seq_word_pkg::DELAY_US[code] * seq_word_pkg::CLK_MHZ);
  assign expired = run && (count_r >= limit);

  always_ff @(posedge mclk) begin
    if (reset || clear || !run) begin
      count_r <= '0;
    end else if (count_r < limit) begin
      count_r <= count_r + CW'(1);
    end
  end
endmodule : delay_timer

/* File: bench/state_word_decoder_asserts.sv */
/*
  Checker for the state word decoder: port-level timing relations.
  Assumes it is bound to state_word_decoder and sees only its ports.
*/
`timescale 1ns/1ps
module state_word_decoder_asserts #(
  parameter int NSTATE = 64,
  parameter int WBITS  = 64,
  parameter int SBITS  = 6
) (
  input wire logic             mclk,
  input wire logic             reset,
  input wire logic             halt,
  input wire logic             global_rr_en,
  input wire logic             ping_rx,
  input wire logic [3:0]       ping_rx_addr,
  input wire logic [3:0]       own_link_addr,
  input wire logic [SBITS-1:0] current_state,
  input wire logic             host_jump_pending,
  input wire logic             monitor_fault,
  input wire logic             round_robin_en,
  input wire logic             ping_tx,
  input wire logic             pong_tx,
  input wire logic             broadcast_tx
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_rr_global: assert property (global_rr_en |-> round_robin_en)
    else $error("round robin off while global enable set");
  a_halt_freeze: assert property (halt |=> current_state == $past(current_state))
    else $error("state moved while halted");
  a_state_settle: assert property ($changed(current_state) |=> $stable(current_state))
    else $error("state moved in the settle cycle");
  a_pong_cause: assert property (pong_tx |-> $past(ping_rx && ping_rx_addr == own_link_addr))
    else $error("pong without matching ping");
  a_ping_single: assert property (ping_tx |=> !ping_tx)
    else $error("ping longer than one cycle");
  a_bcast_cause: assert property (broadcast_tx |-> !$past(halt) && !$past(monitor_fault))
    else $error("broadcast without sequence exit");
  a_bcast_single: assert property (broadcast_tx |=> $fell(broadcast_tx))
    else $error("broadcast longer than one cycle");
  a_pending_hold: assert property (host_jump_pending && halt |=> host_jump_pending)
    else $error("pending host jump lost while halted");

  c_ping: cover property (ping_tx);
  c_pong: cover property (pong_tx);
  c_bcast: cover property (broadcast_tx);
  c_halted_jump: cover property (halt && host_jump_pending);
endmodule : state_word_decoder_asserts

bind state_word_decoder state_word_decoder_asserts #(
  .NSTATE(NSTATE), .WBITS(WBITS), .SBITS(SBITS)) u_asserts (
  .mclk, .reset, .halt, .global_rr_en, .ping_rx, .ping_rx_addr, .own_link_addr,
  .current_state, .host_jump_pending, .monitor_fault, .round_robin_en,
  .ping_tx, .pong_tx, .broadcast_tx);

/* File: bench/link_peer_model.sv */
/*
  Peer sequencer on the interchip link: sends pings on request, counts pongs.
  Assumes requests arrive as one-cycle pulses synchronous to mclk.
*/
`timescale 1ns/1ps
module link_peer_model (
  input  wire logic       mclk,
  input  wire logic       send,
  input  wire logic [3:0] dest,
  input  wire logic       pong_tx,
  output logic            ping_rx,
  output logic [3:0]      ping_rx_addr,
  output int              pongs
);
  initial begin
    ping_rx = 1'b0;
    ping_rx_addr = 4'h0;
    pongs = 0;
  end
  // Address is not held after the ping: it flips to its inverse on every cycle instead
  always @(posedge mclk) begin
    ping_rx <= send;
    ping_rx_addr <= send ? dest : ~ping_rx_addr;
    if (pong_tx === 1'b1) pongs <= pongs + 1;
  end
endmodule : link_peer_model

/* File: bench/test_sequencer_state_word_decoder.sv */
/*
  Bench for the state word decoder: a table of word and input rows, then
  reset, broadcast, link, host, round robin and monitor fault cases. Assumes a 100 MHz mclk.
*/
`timescale 1ns/1ps
module test_sequencer_state_word_decoder;
  typedef struct {logic [63:0] w; logic [10:0] in; int n; logic [5:0] e;} row_t;
  localparam logic [63:0] BC = 64'h8000_0000_0000_0000;
  logic        mclk, reset, cfg_wr_en, halt, host_jump, global_rr_en, send;
  logic [5:0]  cfg_wr_addr, current_state;
  logic [63:0] cfg_wr_data;
  logic [10:0] srcs;
  logic [3:0]  dest, ping_rx_addr, msg_addr, last_addr;
  logic        ping_rx, host_jump_pending, monitor_fault, round_robin_en;
  logic        ping_tx, pong_tx, broadcast_tx;
  int          fails = 0, n_checks = 0, bcasts = 0, pings = 0, pongs;
  row_t        rows[$];

  state_word_decoder u_dut (.mclk, .reset, .cfg_wr_en, .cfg_wr_addr, .cfg_wr_data,
    .positive_supply_inputs(srcs[3:0]), .high_voltage_input(srcs[4]),
    .dual_function_inputs(srcs[9:5]), .warning(srcs[10]), .halt, .host_jump,
    .global_rr_en, .ping_rx, .ping_rx_addr, .own_link_addr(4'h5), .current_state,
    .host_jump_pending, .monitor_fault, .round_robin_en, .ping_tx, .pong_tx,
    .msg_addr, .broadcast_tx);
  link_peer_model u_peer (.mclk, .send, .dest, .pong_tx, .ping_rx, .ping_rx_addr, .pongs);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (broadcast_tx === 1'b1) bcasts <= bcasts + 1;
    if (ping_tx === 1'b1) pings <= pings + 1;
    if ((ping_tx | pong_tx) === 1'b1) last_addr <= msg_addr;
  end

  // Targets: monitor 1, expiry 2, advance 3
  function automatic logic [63:0] wd(input logic [3:0] s, input logic p,
      input logic [3:0] d, input logic [3:0] t, input logic [10:0] m);
    return {2'b00, 6'h03, 6'h02, 6'h01, d, p, s, t, m, 20'h0_0000};
  endfunction : wd

  task automatic chk(input logic [5:0] g, input logic [5:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [63:0] w);
    @(posedge mclk);
    cfg_wr_en <= 1'b1;
    cfg_wr_addr <= a;
    cfg_wr_data <= w;
    @(posedge mclk);
    cfg_wr_en <= 1'b0;
  endtask : wr

  // Reset for 6 edges, load state 0, release and wait n edges
  task automatic run(input logic [63:0] w, input logic [10:0] in, input int n);
    @(posedge mclk);
    reset <= 1'b1;
    srcs <= 11'h000;
    wr(6'h00, w);
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    srcs <= in;
    repeat (n) @(posedge mclk);
    #1;
  endtask : run

  task automatic ping(input logic [3:0] a);
    @(posedge mclk);
    send <= 1'b1;
    dest <= a;
    @(posedge mclk);
    send <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
  endtask : ping

  task automatic hj();
    @(posedge mclk);
    host_jump <= 1'b1;
    @(posedge mclk);
    host_jump <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask : hj

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Tests take about 40k cycles; give up at twice that
  initial begin
    #800_000;
    fails++;
    print_verdict();
  end

  initial begin
    {reset, cfg_wr_en, halt, host_jump, global_rr_en, send} = 6'h20;
    {cfg_wr_addr, cfg_wr_data, srcs, dest} = '0;
    for (int a = 1; a < 4; a++) wr(a[5:0], '0);
    for (int s = 1; s < 12; s++) rows.push_back('{wd(s[3:0], 1'b0, 4'h0, 4'h0, 11'h000),
      11'h001 << (s - 1), 8, 6'h03});
    rows.push_back('{wd(4'h1, 1'b1, 4'h0, 4'h0, 11'h000), 11'h001, 8, 6'h00});
    rows.push_back('{wd(4'h1, 1'b1, 4'h0, 4'h0, 11'h000), 11'h000, 8, 6'h03});
    rows.push_back('{wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h080), 11'h000, 8, 6'h01});
    rows.push_back('{wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h000), 11'h000, 8, 6'h00});
    rows.push_back('{wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h300), 11'h200, 8, 6'h01});
    rows.push_back('{wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h100), 11'h200, 8, 6'h00});
    rows.push_back('{wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h400), 11'h400, 8, 6'h01});
    rows.push_back('{wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h400), 11'h000, 8, 6'h00});
    rows.push_back('{wd(4'h1, 1'b0, 4'h0, 4'h0, 11'h400), 11'h401, 8, 6'h01});
    rows.push_back('{wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h000) | 64'h800, 11'h000, 8, 6'h01});
    rows.push_back('{wd(4'h0, 1'b0, 4'h0, 4'h1, 11'h000), 11'h000, 9900, 6'h00});
    rows.push_back('{wd(4'h0, 1'b0, 4'h0, 4'h1, 11'h000), 11'h000, 10050, 6'h02});
    rows.push_back('{wd(4'h1, 1'b0, 4'h1, 4'h0, 11'h000), 11'h001, 9900, 6'h00});
    rows.push_back('{wd(4'h1, 1'b0, 4'h1, 4'h0, 11'h000), 11'h001, 10050, 6'h03});
    foreach (rows[i]) begin
      run(rows[i].w, rows[i].in, rows[i].n);
      chk(current_state, rows[i].e);
      $display("row %0d done", i);
    end
    run(wd(4'h1, 1'b0, 4'h0, 4'h0, 11'h000), 11'h001, 0);
    chk(current_state, 6'h00);
    run(wd(4'h1, 1'b0, 4'h0, 4'h0, 11'h000) | BC, 11'h001, 8);
    chk(bcasts[5:0], 6'h01);
    run(wd(4'h1, 1'b0, 4'h0, 4'h0, 11'h400) | BC, 11'h401, 8);
    chk(bcasts[5:0], 6'h01);
    $display("broadcast test done");
    run(wd(4'he, 1'b0, 4'h9, 4'h0, 11'h000), 11'h000, 8);
    chk(current_state, 6'h03);
    chk({pings[1:0], last_addr}, 6'h19);
    run(wd(4'hf, 1'b0, 4'h6, 4'h0, 11'h000), 11'h000, 4);
    ping(4'h2);
    chk({pongs[1:0], current_state[3:0]}, 6'h00);
    ping(4'h5);
    chk({pongs[1:0], current_state[3:0]}, 6'h13);
    chk({2'b00, last_addr}, 6'h06);
    $display("link test done");
    run(wd(4'hc, 1'b0, 4'h0, 4'h0, 11'h000), 11'h000, 8);
    chk(current_state, 6'h00);
    @(posedge mclk);
    halt <= 1'b1;
    hj();
    chk({host_jump_pending, current_state[4:0]}, 6'h20);
    @(posedge mclk);
    halt <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk({host_jump_pending, current_state[4:0]}, 6'h03);
    run(wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h000), 11'h000, 4);
    hj();
    chk(current_state, 6'h01);
    chk({5'h00, round_robin_en}, 6'h00);
    @(posedge mclk);
    global_rr_en <= 1'b1;
    @(posedge mclk);
    #1 chk({5'h00, round_robin_en}, 6'h01);
    @(posedge mclk);
    global_rr_en <= 1'b0;
    run(wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h000) | 64'h4000_0000_0000_0000, 11'h000, 4);
    chk({5'h00, round_robin_en}, 6'h01);
    $display("host and round robin tests done");
    @(posedge mclk);
    halt <= 1'b1;
    run(wd(4'h0, 1'b0, 4'h0, 4'h0, 11'h400), 11'h400, 4);
    chk({4'h0, monitor_fault, current_state[0]}, 6'h02);
    @(posedge mclk);
    halt <= 1'b0;
    $display("monitor fault level test done");
    print_verdict();
  end
endmodule : test_sequencer_state_word_decoder
